// File: ptr_pkg.sv
// ptr_pkg.sv: constants, register map and states of the tdc readout
// assumes one clock; one delay-line tap advances per clock (1 ns of time)
// ****************************************************************
// How it works
// R1 - each input shifts through 48 taps; every 48 taps the line is snapshot
// R2 - snapshots enter a latency memory holding 5.2 us of history
// R3 - first-level accept copies leaving words into the named one of four buffers
// R4 - each second-level buffer holds forty-two 48-bit snapshot words
// R5 - consecutive accepts fill several buffers, each window offset in time
// R6 - the trigger party spaces first-level accepts at least 96 ns apart
// R7 - accept shifts through its own 48-tap line, copied per buffer
// R8 - second-level accept first derives reference time from stored accept line
// R9 - the selected buffer is scanned for every rising and falling transition
// R10 - time minus reference in 11 bits, top bit marks trailing edge
// R11 - 12-bit hit words go into a 16-word hit queue
// R12 - each input selects live signal or one of three calibration pulses
// R13 - readout takes hit words only while the hit queue reports data
// R14 - leading and trailing edges pair into width, lead time, channel word
// R15 - optional cut drops pulses narrower than a programmed minimum
// R16 - optional cut drops hits later than a programmed maximum drift
// R17 - optional per-channel hit cap; bad channels are skipped entirely
// R18 - after all channels: header, word count, then data into bus queue
// R19 - header carries module identifier and event number
// R20 - time field counts 1 ns steps across the 2016 ns window
// ****************************************************************
package ptr_pkg;
  localparam int TAP_NS    = 1;
  localparam int DL_LEN    = 48;
  localparam int SNAP_NS   = 48;
  localparam int SNAP_CYC  = SNAP_NS / TAP_NS;
  localparam int LAT_NS    = 5200;
  localparam int LAT_DEPTH = (LAT_NS + SNAP_NS - 1) / SNAP_NS;
  localparam int N_L2      = 4;
  localparam int L2_WORDS  = 42;
  localparam int HF_DEPTH  = 16;
  localparam int TW        = 11;
  localparam int N_CAL     = 3;
  localparam int CALW      = 8;
  // register byte addresses
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_MINW  = 8'h04;
  localparam logic [7:0] A_MAXD  = 8'h08;
  localparam logic [7:0] A_HCAP  = 8'h0C;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam logic [7:0] A_DATA  = 8'h14;
  localparam logic [7:0] A_MODID = 8'h18;
  localparam logic [7:0] A_EVT   = 8'h1C;
  localparam logic [7:0] A_CALCF = 8'h20;
  localparam logic [7:0] A_CALGO = 8'h24;
  localparam logic [7:0] A_BAD   = 8'h40;
  localparam logic [7:0] A_CALM  = 8'h60;
  localparam logic [7:0] CALM_STEP = 8'h10;
  // control and status bits and reset values
  localparam int C_MINW = 0;
  localparam int C_MAXD = 1;
  localparam int C_HCAP = 2;
  localparam int S_BUSY = 31;
  localparam int S_AVL  = 30;
  localparam logic [TW-1:0] MAXD_RST = 11'h7FF;
  localparam logic [7:0]    HCAP_RST = 8'hFF;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_REF   = 5'h02,
    ST_SCAN  = 5'h04,
    ST_DRAIN = 5'h08,
    ST_DONE  = 5'h10
  } ptr_state_t;
endpackage

// File: ptr_tdc_readout.sv
// ptr_tdc_readout.sv: capture, trigger buffering, encoding and readout
// assumes inputs synchronous to mclk and a single-cycle register port
`timescale 1ns/1ns
module ptr_tdc_readout #(
  parameter int          NCH       = 96,
  parameter int          OUT_DEPTH = 256,
  parameter logic [15:0] MODID_RST = 16'h0001 // arbitrary value
) (
  input  logic             mclk,
  input  logic             reset_n,
  input  logic [NCH-1:0]   hit_in,
  input  logic             l1_accept,
  input  logic [1:0]       l1_buf,
  input  logic             l2_accept,
  input  logic [1:0]       l2_buf,
  input  logic [7:0]       addr,
  input  logic [31:0]      wdata,
  input  logic             wr,
  input  logic             rd,
  output logic [31:0]      rdata,
  output logic             busy
);
  localparam int NW  = (NCH + 31) / 32;
  localparam int CW  = $clog2(NCH);
  localparam int OAW = $clog2(OUT_DEPTH);
  localparam int LAW = $clog2(ptr_pkg::LAT_DEPTH);
  localparam int HAW = $clog2(ptr_pkg::HF_DEPTH);
  localparam int TW  = ptr_pkg::TW;

  logic [5:0]           snap_cnt_r;
  logic                 snap_en;
  logic                 snap_d_r;
  logic [LAW-1:0]       lat_wp_r;
  logic [47:0]          acc_dl_r;
  logic [47:0]          acc_t_r [ptr_pkg::N_L2];
  logic [3:0]           pend_r;
  logic [3:0]           cap_act_r;
  logic [5:0]           cap_idx_r [ptr_pkg::N_L2];
  logic [2:0]           ctrl_r;
  logic [TW-1:0]        minw_r;
  logic [TW-1:0]        maxd_r;
  logic [7:0]           hcap_r;
  logic [15:0]          modid_r;
  logic [15:0]          evt_r;
  logic [23:0]          calcf_r;
  logic [31:0]          bad_r  [NW];
  logic [31:0]          calm_r [ptr_pkg::N_CAL][NW];
  logic [7:0]           calc_r [ptr_pkg::N_CAL];
  logic [2:0]           cal_pulse;
  logic [NCH-1:0]       scan_v;
  logic [NCH-1:0]       bad_v;
  ptr_pkg::ptr_state_t  state_r;
  logic [CW-1:0]        ch_r;
  logic [1:0]           sel_b_r;
  logic [5:0]           ref_r;
  logic [5:0]           w_idx_r;
  logic [5:0]           b_idx_r;
  logic [TW-1:0]        idx_r;
  logic                 prev_r;
  logic                 last_bit;
  logic                 edge_now;
  logic [TW:0]          hf_m [ptr_pkg::HF_DEPTH];
  logic [HAW:0]         hf_wp_r;
  logic [HAW:0]         hf_rp_r;
  logic                 hf_full;
  logic                 hf_has;
  logic                 hf_push;
  logic                 hf_pop;
  logic [TW:0]          hf_head;
  logic                 have_lead_r;
  logic [TW-1:0]        lead_r;
  logic [7:0]           nhits_r;
  logic [TW-1:0]        width;
  logic                 keep;
  logic                 o_we;
  logic [31:0]          of_m [OUT_DEPTH];
  logic [OAW-1:0]       o_wp_r;
  logic [OAW-1:0]       o_rp_r;
  logic [OAW-1:0]       o_hp_r;
  logic [OAW-1:0]       o_cp_r;
  logic [15:0]          o_cnt_r;
  logic [OAW-1:0]       o_used;
  logic                 o_avl;
  logic                 l2_go;
  logic                 rd_pop;
  logic [31:0]          rdata_r;
  logic                 busy_r;

  // reference = scan position (47 minus age) of the oldest accept tap in the stored line
  function automatic logic [5:0] ref_of(input logic [47:0] v);
    logic [5:0] r;
    r = '0;
    for (int i = 0; i < ptr_pkg::DL_LEN; i++) begin
      if (v[i]) begin
        r = 6'(ptr_pkg::DL_LEN - 1 - i);
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // snapshot divider and accept line
  // ****************************************************************
  assign snap_en = (snap_cnt_r == 6'(ptr_pkg::SNAP_CYC - 1)); // R1
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      snap_cnt_r <= '0;
      snap_d_r   <= 1'b0;
      lat_wp_r   <= '0;
      acc_dl_r   <= '0;
    end else begin
      snap_cnt_r <= snap_en ? 6'h00 : snap_cnt_r + 6'h01;
      snap_d_r   <= snap_en;
      acc_dl_r   <= {acc_dl_r[46:0], l1_accept}; // R7
      if (snap_en) begin
        lat_wp_r <= (lat_wp_r == LAW'(ptr_pkg::LAT_DEPTH - 1)) ?
                    '0 : lat_wp_r + 1'b1; // R2
      end
    end
  end

  // per-buffer capture windows run independently, so back-to-back
  // accepts land in separate buffers two snapshots apart
  generate
    for (genvar b = 0; b < ptr_pkg::N_L2; b++) begin : g_buf
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          pend_r[b]    <= 1'b0;
          cap_act_r[b] <= 1'b0;
          cap_idx_r[b] <= '0;
          acc_t_r[b]   <= '0;
        end else begin
          if (snap_en) begin
            pend_r[b] <= 1'b0;
          end
          if (l1_accept && l1_buf == 2'(b)) begin
            pend_r[b] <= 1'b1; // R3
          end
          if (snap_en && pend_r[b]) begin
            acc_t_r[b]   <= acc_dl_r; // R7
            cap_act_r[b] <= 1'b1; // R5
            cap_idx_r[b] <= '0;
          end else if (snap_d_r && cap_act_r[b]) begin
            cap_idx_r[b] <= cap_idx_r[b] + 6'h01;
            if (cap_idx_r[b] == 6'(ptr_pkg::L2_WORDS - 1)) begin
              cap_act_r[b] <= 1'b0; // R4
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // channel front ends
  // ****************************************************************
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic        cal_sel;
      logic        cal_src;
      logic        src;
      logic [47:0] dl_r;
      logic [47:0] lat_out_r;
      logic [47:0] lat_m [ptr_pkg::LAT_DEPTH];
      logic [47:0] l2_m [ptr_pkg::N_L2][ptr_pkg::L2_WORDS];
      logic [2:0]  cm;
      for (genvar k = 0; k < ptr_pkg::N_CAL; k++) begin : g_cm
        assign cm[k] = calm_r[k][c / 32][c % 32];
      end
      assign cal_sel = |cm;
      assign cal_src = |(cm & cal_pulse);
      assign src = cal_sel ? cal_src : hit_in[c]; // R12
      assign bad_v[c] = bad_r[c / 32][c % 32];
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          dl_r <= '0;
        end else begin
          dl_r <= {dl_r[46:0], src}; // R1
        end
      end
      // storage has no reset; the window start overwrites it
      always_ff @(posedge mclk) begin
        if (snap_en) begin
          lat_m[lat_wp_r] <= dl_r; // R2
          lat_out_r       <= lat_m[lat_wp_r];
        end
        for (int b = 0; b < ptr_pkg::N_L2; b++) begin
          if (snap_d_r && cap_act_r[b]) begin
            l2_m[b][cap_idx_r[b]] <= lat_out_r; // R3
          end
        end
      end
      assign scan_v[c] = l2_m[sel_b_r][w_idx_r][b_idx_r];
    end
  endgenerate

  // ****************************************************************
  // encoder: scans one channel bit by bit, oldest bit first
  // ****************************************************************
  assign last_bit = (w_idx_r == 6'(ptr_pkg::L2_WORDS - 1)) &&
                    (b_idx_r == 6'h00);
  assign edge_now = scan_v[ch_r] ^ prev_r; // R9
  assign hf_push  = (state_r == ptr_pkg::ST_SCAN) && !bad_v[ch_r] &&
                    !hf_full && edge_now && (idx_r >= TW'(ref_r));
  assign l2_go    = (state_r == ptr_pkg::ST_IDLE) && l2_accept &&
                    (o_used < OAW'(OUT_DEPTH - 2));
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ptr_pkg::ST_IDLE;
      ch_r    <= '0;
      sel_b_r <= '0;
      ref_r   <= '0;
      w_idx_r <= '0;
      b_idx_r <= '0;
      idx_r   <= '0;
      prev_r  <= 1'b0;
      evt_r   <= '0;
    end else begin
      unique case (state_r)
        ptr_pkg::ST_IDLE: begin
          if (l2_go) begin
            sel_b_r <= l2_buf;
            state_r <= ptr_pkg::ST_REF;
          end
        end
        ptr_pkg::ST_REF: begin
          ref_r   <= ref_of(acc_t_r[sel_b_r]); // R8
          ch_r    <= '0;
          w_idx_r <= '0;
          b_idx_r <= 6'(ptr_pkg::DL_LEN - 1);
          idx_r   <= '0;
          prev_r  <= 1'b0;
          state_r <= ptr_pkg::ST_SCAN;
        end
        ptr_pkg::ST_SCAN: begin
          if (bad_v[ch_r] || (last_bit && !hf_full)) begin
            state_r <= ptr_pkg::ST_DRAIN; // R17
          end
          if (!hf_full) begin
            prev_r <= scan_v[ch_r];
            idx_r  <= idx_r + 1'b1; // R20
            if (b_idx_r == 6'h00) begin
              b_idx_r <= 6'(ptr_pkg::DL_LEN - 1);
              w_idx_r <= w_idx_r + 6'h01;
            end else begin
              b_idx_r <= b_idx_r - 6'h01;
            end
          end
        end
        ptr_pkg::ST_DRAIN: begin
          if (!hf_has) begin
            w_idx_r <= '0;
            b_idx_r <= 6'(ptr_pkg::DL_LEN - 1);
            idx_r   <= '0;
            prev_r  <= 1'b0;
            ch_r    <= ch_r + 1'b1;
            state_r <= (ch_r == CW'(NCH - 1)) ?
                       ptr_pkg::ST_DONE : ptr_pkg::ST_SCAN;
          end
        end
        ptr_pkg::ST_DONE: begin
          evt_r   <= evt_r + 16'h0001;
          state_r <= ptr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // hit queue between encoder and pairing stage
  assign hf_full = (hf_wp_r - hf_rp_r) == (HAW + 1)'(ptr_pkg::HF_DEPTH);
  assign hf_has  = (hf_wp_r != hf_rp_r);
  assign hf_head = hf_m[hf_rp_r[HAW-1:0]];
  always_ff @(posedge mclk) begin
    if (hf_push) begin
      hf_m[hf_wp_r[HAW-1:0]] <= {prev_r, idx_r - TW'(ref_r)}; // R10 R11
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hf_wp_r <= '0;
      hf_rp_r <= '0;
    end else begin
      hf_wp_r <= hf_wp_r + (HAW + 1)'(hf_push);
      hf_rp_r <= hf_rp_r + (HAW + 1)'(hf_pop);
    end
  end

  // ****************************************************************
  // pairing and cuts
  // ****************************************************************
  assign hf_pop = hf_has && !(&o_used); // R13
  assign width  = hf_head[TW-1:0] - lead_r;
  assign keep   = !(ctrl_r[ptr_pkg::C_MINW] && width < minw_r) && // R15
                  !(ctrl_r[ptr_pkg::C_MAXD] && lead_r > maxd_r) && // R16
                  !(ctrl_r[ptr_pkg::C_HCAP] && nhits_r >= hcap_r); // R17
  assign o_we   = hf_pop && hf_head[TW] &&
                  have_lead_r && keep; // R14
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      have_lead_r <= 1'b0;
      lead_r      <= '0;
      nhits_r     <= '0;
    end else if (state_r != ptr_pkg::ST_SCAN &&
                 state_r != ptr_pkg::ST_DRAIN || !hf_has &&
                 state_r == ptr_pkg::ST_DRAIN) begin
      have_lead_r <= 1'b0;
      nhits_r     <= '0;
    end else if (hf_pop) begin
      if (!hf_head[TW]) begin
        have_lead_r <= 1'b1;
        lead_r      <= hf_head[TW-1:0];
      end else begin
        have_lead_r <= 1'b0;
        nhits_r     <= nhits_r + 8'(o_we);
      end
    end
  end

  // ****************************************************************
  // bus output queue: header and count slots reserved at the start,
  // filled and made visible only when the event is complete
  // ****************************************************************
  assign o_used = o_wp_r - o_rp_r;
  assign o_avl  = (o_rp_r != o_cp_r);
  assign rd_pop = rd && (addr == ptr_pkg::A_DATA) && o_avl;
  always_ff @(posedge mclk) begin
    if (o_we) begin
      of_m[o_wp_r] <= 32'({width, lead_r, ch_r}); // R14
    end
    if (state_r == ptr_pkg::ST_DONE) begin
      of_m[o_hp_r]        <= {modid_r, evt_r}; // R19
      of_m[o_hp_r + 1'b1] <= 32'(o_cnt_r); // R18
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      o_wp_r  <= '0;
      o_rp_r  <= '0;
      o_hp_r  <= '0;
      o_cp_r  <= '0;
      o_cnt_r <= '0;
    end else begin
      if (l2_go) begin
        o_hp_r  <= o_wp_r;
        o_wp_r  <= o_wp_r + OAW'(2); // R18
        o_cnt_r <= '0;
      end else if (o_we) begin
        o_wp_r  <= o_wp_r + 1'b1;
        o_cnt_r <= o_cnt_r + 16'h0001;
      end
      if (state_r == ptr_pkg::ST_DONE) begin
        o_cp_r <= o_wp_r; // R18
      end
      if (rd_pop) begin
        o_rp_r <= o_rp_r + 1'b1;
      end
    end
  end

  // ****************************************************************
  // registers and calibration pulses
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r  <= '0;
      minw_r  <= '0;
      maxd_r  <= ptr_pkg::MAXD_RST;
      hcap_r  <= ptr_pkg::HCAP_RST;
      modid_r <= MODID_RST;
      calcf_r <= '0;
      for (int i = 0; i < NW; i++) begin
        bad_r[i] <= '0;
        for (int k = 0; k < ptr_pkg::N_CAL; k++) begin
          calm_r[k][i] <= '0;
        end
      end
    end else if (wr) begin
      case (addr)
        ptr_pkg::A_CTRL:  ctrl_r  <= wdata[2:0];
        ptr_pkg::A_MINW:  minw_r  <= wdata[TW-1:0];
        ptr_pkg::A_MAXD:  maxd_r  <= wdata[TW-1:0];
        ptr_pkg::A_HCAP:  hcap_r  <= wdata[7:0];
        ptr_pkg::A_MODID: modid_r <= wdata[15:0];
        ptr_pkg::A_CALCF: calcf_r <= wdata[23:0];
        default: ;
      endcase
      for (int i = 0; i < NW; i++) begin
        if (addr == ptr_pkg::A_BAD + 8'(4 * i)) begin
          bad_r[i] <= wdata; // R17
        end
        for (int k = 0; k < ptr_pkg::N_CAL; k++) begin
          if (addr == ptr_pkg::A_CALM + 8'(16 * k + 4 * i)) begin
            calm_r[k][i] <= wdata; // R12
          end
        end
      end
    end
  end
  // each pulse lasts its programmed count of clocks after a fire write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < ptr_pkg::N_CAL; k++) begin
        calc_r[k] <= '0;
      end
    end else begin
      for (int k = 0; k < ptr_pkg::N_CAL; k++) begin
        if (wr && addr == ptr_pkg::A_CALGO && wdata[k]) begin
          calc_r[k] <= calcf_r[k * ptr_pkg::CALW +: ptr_pkg::CALW];
        end else if (calc_r[k] != 8'h00) begin
          calc_r[k] <= calc_r[k] - 8'h01;
        end
      end
    end
  end
  for (genvar k = 0; k < ptr_pkg::N_CAL; k++) begin : g_cp
    assign cal_pulse[k] = (calc_r[k] != 8'h00); // R12
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= '0;
      busy_r  <= 1'b0;
    end else begin
      busy_r  <= (state_r != ptr_pkg::ST_IDLE) || l2_go;
      rdata_r <= '0;
      if (rd) begin
        case (addr)
          ptr_pkg::A_CTRL:  rdata_r <= 32'(ctrl_r);
          ptr_pkg::A_MINW:  rdata_r <= 32'(minw_r);
          ptr_pkg::A_MAXD:  rdata_r <= 32'(maxd_r);
          ptr_pkg::A_HCAP:  rdata_r <= 32'(hcap_r);
          ptr_pkg::A_MODID: rdata_r <= 32'(modid_r);
          ptr_pkg::A_EVT:   rdata_r <= 32'(evt_r);
          ptr_pkg::A_CALCF: rdata_r <= 32'(calcf_r);
          ptr_pkg::A_DATA:  rdata_r <= o_avl ? of_m[o_rp_r] : 32'h0;
          ptr_pkg::A_STAT: begin
            rdata_r <= 32'(o_cp_r - o_rp_r);
            rdata_r[ptr_pkg::S_BUSY] <= busy_r; // same view as busy pin
            rdata_r[ptr_pkg::S_AVL]  <= o_avl;
          end
          default: begin
            for (int i = 0; i < NW; i++) begin
              if (addr == ptr_pkg::A_BAD + 8'(4 * i)) begin
                rdata_r <= bad_r[i];
              end
            end
          end
        endcase
      end
    end
  end
  assign rdata = rdata_r;
  assign busy  = busy_r;
endmodule

// File: ptr_tdc_readout_asserts.sv
// checker for the tdc readout: register answers and engine status
// assumes it is bound to ptr_tdc_readout and sees only its ports
`timescale 1ns/1ns
module ptr_chk #(
  parameter int NCH = 96
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        l2_accept,
  input wire logic [31:0] rdata,
  input wire logic        busy
);
  logic [31:0] busy_cnt_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // length of the current busy run; a hung engine trips the bound
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= busy ? busy_cnt_r + 32'h1 : 32'h0;
  end
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside an answer");
  chk_busy_cause: assert property ($rose(busy) |-> $past(l2_accept))
    else $error("busy rose without a second-level accept");
  chk_busy_hold: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped right after it rose");
  chk_unmapped_read: assert property (rd && addr == 8'h3C |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_minw_back: assert property (wr && addr == ptr_pkg::A_MINW ##1
    rd && addr == ptr_pkg::A_MINW |=> rdata == {21'h0, $past(wdata[10:0], 2)})
    else $error("min width readback wrong");
  chk_hcap_back: assert property (wr && addr == ptr_pkg::A_HCAP ##1
    rd && addr == ptr_pkg::A_HCAP |=> rdata == {24'h0, $past(wdata[7:0], 2)})
    else $error("hit cap readback wrong");
  chk_modid_back: assert property (wr && addr == ptr_pkg::A_MODID ##1
    rd && addr == ptr_pkg::A_MODID |=> rdata == {16'h0, $past(wdata[15:0], 2)})
    else $error("module id readback wrong");
  chk_stat_busy: assert property (rd && addr == ptr_pkg::A_STAT
    |=> rdata[31] == $past(busy))
    else $error("status busy bit differs from busy");
  chk_busy_bound: assert property (busy_cnt_r <= 32'(NCH * 4000))
    else $error("event processing too long");
endmodule
bind ptr_tdc_readout ptr_chk #(.NCH(NCH)) ptr_chk_inst (
  .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .l2_accept(l2_accept), .rdata(rdata), .busy(busy));

// File: ptr_trig_model.sv
// trigger supervisor model: first- and second-level accepts
// assumes its tasks are called right after a rising mclk edge
`timescale 1ns/1ns
module ptr_trig (
  input  wire logic  mclk,
  input  wire logic  reset_n,
  output logic       l1_accept,
  output logic [1:0] l1_buf,
  output logic       l2_accept,
  output logic [1:0] l2_buf
);
  int cyc  = 0;
  int last = -1000;
  // idle levels at time zero
  initial begin
    l1_accept = 1'b0;
    l1_buf    = 2'h0;
    l2_accept = 1'b0;
    l2_buf    = 2'h0;
  end
  // cycle count for accept spacing
  always @(posedge mclk) cyc <= reset_n ? cyc + 1 : 0;
  // buffer index is scrambled after the pulse so stale values are useless
  task automatic l1(input logic [1:0] b);
    while (cyc - last < 96)
      @(posedge mclk);
    l1_accept <= 1'b1;
    l1_buf    <= b;
    last = cyc;
    @(posedge mclk);
    l1_accept <= 1'b0;
    l1_buf    <= ~b;
  endtask
  task automatic l2(input logic [1:0] b);
    l2_accept <= 1'b1;
    l2_buf    <= b;
    @(posedge mclk);
    l2_accept <= 1'b0;
    l2_buf    <= ~b;
  endtask
endmodule

// File: tb_top.sv
// bench for the tdc readout: registers, cuts and one framed event
// assumes the trigger model and the bound checker are compiled first
`timescale 1ns/1ns
module tb_top;
  localparam int          NCH  = 32;
  localparam logic [31:0] ALL  = 32'hFFFFFFFF;
  localparam logic [31:0] LMSK = 32'hFFFF001F; // lead time not fixed
  logic            mclk;
  logic            reset_n;
  logic [NCH-1:0]  hit_in;
  logic            l1_accept;
  logic [1:0]      l1_buf;
  logic            l2_accept;
  logic [1:0]      l2_buf;
  logic [7:0]      addr;
  logic [31:0]     wdata;
  logic            wr;
  logic            rd;
  logic [31:0]     rdata;
  logic            busy;
  int              fail_count = 0;
  int              n_compared = 0;
  logic [31:0]     exp_q[$];
  logic [31:0]     msk_q[$];
  string           nam_q[$];
  logic [31:0]     got[$];
  logic            pend = 1'b0;
  logic [15:0]     modid;
  int              pc[7] = '{3, 3, 5, 5, 5, 7, 9};
  int              ps[7] = '{0, 40, 100, 150, 200, 0, 1000};
  int              pw[7] = '{20, 9, 15, 15, 15, 12, 10};
  ptr_tdc_readout #(.NCH(NCH), .OUT_DEPTH(256)) ptr_tdc_readout_inst (
    .mclk(mclk), .reset_n(reset_n), .hit_in(hit_in),
    .l1_accept(l1_accept), .l1_buf(l1_buf), .l2_accept(l2_accept),
    .l2_buf(l2_buf), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .busy(busy));
  ptr_trig trig_inst (
    .mclk(mclk), .reset_n(reset_n), .l1_accept(l1_accept),
    .l1_buf(l1_buf), .l2_accept(l2_accept), .l2_buf(l2_buf));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic cmp_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // strobes stay driven between calls, so no signal is set twice a step
  task automatic wrx(input logic [7:0] a, input logic [31:0] d);
    wr    <= 1'b1;
    rd    <= 1'b0;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
  endtask
  task automatic rdx(input string nm, input logic [7:0] a,
                     input logic [31:0] e, input logic [31:0] m);
    nam_q.push_back(nm);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    wr   <= 1'b0;
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
  endtask
  task automatic idle;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask
  // answer stands the cycle after the strobe; sampled at its closing edge
  always @(posedge mclk) begin
    if (pend && exp_q.size() > 0) begin
      got.push_back(rdata);
      cmp_word(nam_q.pop_front(), exp_q.pop_front(), rdata & msk_q.pop_front());
    end
    pend <= rd;
  end
  // watchdog well beyond one event scan
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    end_sim;
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [31:0] h;
    logic [10:0] maxd;
    int          n;
    hit_in  = '0;
    addr    = 8'h00;
    wdata   = 32'h0;
    wr      = 1'b0;
    rd      = 1'b0;
    reset_n = 1'b0;
    void'($urandom(93249));
    modid = 16'($urandom());
    maxd  = 11'(850 + $urandom_range(100));
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rdx("ctrl", ptr_pkg::A_CTRL, 32'h0, ALL);
    rdx("minw", ptr_pkg::A_MINW, 32'h0, ALL);
    rdx("maxd", ptr_pkg::A_MAXD, 32'h7FF, ALL);
    rdx("hcap", ptr_pkg::A_HCAP, 32'hFF, ALL);
    rdx("modid", ptr_pkg::A_MODID, 32'h1, ALL);
    rdx("evt", ptr_pkg::A_EVT, 32'h0, ALL);
    rdx("stat", ptr_pkg::A_STAT, 32'h0, ALL);
    wrx(8'h3C, ALL);
    rdx("unmapped", 8'h3C, 32'h0, ALL);
    wrx(ptr_pkg::A_MINW, 32'hA);
    rdx("minw", ptr_pkg::A_MINW, 32'hA, ALL);
    wrx(ptr_pkg::A_MAXD, {21'h0, maxd});
    rdx("maxd", ptr_pkg::A_MAXD, {21'h0, maxd}, ALL);
    wrx(ptr_pkg::A_HCAP, 32'h2);
    rdx("hcap", ptr_pkg::A_HCAP, 32'h2, ALL);
    wrx(ptr_pkg::A_MODID, {16'h0, modid});
    rdx("modid", ptr_pkg::A_MODID, {16'h0, modid}, ALL);
    wrx(ptr_pkg::A_BAD, 32'h80);
    rdx("bad", ptr_pkg::A_BAD, 32'h80, ALL);
    wrx(ptr_pkg::A_CTRL, 32'h7);
    idle;
    // clean history first: memories hold junk until refilled
    repeat (400) @(posedge mclk);
    for (int t = 0; t < 1200; t++) begin
      h = '0;
      for (int i = 0; i < 7; i++)
        if (t >= ps[i] && t < ps[i] + pw[i])
          h[pc[i]] = 1'b1;
      hit_in <= h;
      @(posedge mclk);
    end
    // accept 300 ns short of the latency so pulses land early in the window
    repeat (3732) @(posedge mclk);
    trig_inst.l1(2'h1);
    repeat (131) @(posedge mclk);
    trig_inst.l1(2'h2);
    repeat (2200) @(posedge mclk);
    trig_inst.l2(2'h1);
    #1;
    cmp_word("busy", 32'h1, {31'h0, busy});
    trig_inst.l2(2'h1);
    n = 0;
    while (busy !== 1'b0 && n < 80000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    rdx("stat", ptr_pkg::A_STAT, 32'h40000005, ALL);
    rdx("evt", ptr_pkg::A_EVT, 32'h1, ALL);
    rdx("header", ptr_pkg::A_DATA, {modid, 16'h0}, ALL);
    rdx("count", ptr_pkg::A_DATA, 32'h3, ALL);
    rdx("hit ch3", ptr_pkg::A_DATA, 32'h00140003, LMSK);
    rdx("hit ch5", ptr_pkg::A_DATA, 32'h000F0005, LMSK);
    rdx("hit ch5", ptr_pkg::A_DATA, 32'h000F0005, LMSK);
    rdx("empty", ptr_pkg::A_DATA, 32'h0, ALL);
    rdx("stat", ptr_pkg::A_STAT, 32'h0, ALL);
    idle;
    @(posedge mclk);
    cmp_word("lead gap", 32'd100,
      32'(got[$-3][15:5]) - 32'(got[$-4][15:5]));
    cmp_word("lead gap", 32'd50,
      32'(got[$-2][15:5]) - 32'(got[$-3][15:5]));
    end_sim;
  end
endmodule
